/* File: dv/diode_front_model.sv */
// behavioural remote diode and converter answering the excitation requests
`timescale 1ns/1ns

module diode_front_model (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire temp_fmt_pkg::adc_req_t adc_req,
	input  wire logic [35:0]            temp_q,
	output logic                        adc_done = 1'b0,
	output logic [9:0]                  adc_code = 10'h155
);
	// ---------------------------------------------------------------
	// conversion answer
	// ---------------------------------------------------------------
	int         lat = 0;
	int         k = 0;
	int         t;
	int         d2;
	logic [9:0] code = 10'h000;
	logic [2:0] tog = 3'b000;

	// noise of +-1 degree alternates per measurement, so only a true
	// sixteen-sample average gives the clean temperature back
	always @(posedge clk) begin
		adc_code <= ~adc_code;
		adc_done <= 1'b0;
		if (rst) begin
			lat = 0;
			tog = 3'b000;
		end else if (adc_req.start) begin
			t = $signed(temp_q[12*adc_req.chan +: 12]);
			t = t + (tog[adc_req.chan] ? 4 : -4);
			d2 = 200 + (t & 1);
			case (adc_req.cur)
			temp_fmt_pkg::CUR_FIRST_MULT:  code = 10'(300 + (t + d2) / 2);
			temp_fmt_pkg::CUR_SECOND_MULT: code = 10'(300 + d2);
			default:                       code = 10'(300);
			endcase
			if (adc_req.chan == temp_fmt_pkg::CH_LOCAL)
				code = 10'(t + 256);
			if (adc_req.chan == temp_fmt_pkg::CH_LOCAL ||
			    adc_req.cur == temp_fmt_pkg::CUR_SECOND_MULT)
				tog[adc_req.chan] = ~tog[adc_req.chan];
			// latency walks 1..11 cycles: prompt and slow answers
			lat = 1 + k % 11;
			k++;
		end else if (lat > 0) begin
			lat--;
			if (lat == 0) begin
				adc_done <= 1'b1;
				adc_code <= code;
			end
		end
	end

endmodule // diode_front_model

/* File: dv/tb.sv */
// self-checking bench of the temperature result formatter
`timescale 1ns/1ns

module tb;
	localparam int SETTLE_CYC = 2;
	localparam int AVG_COUNT  = 16;

	logic                   clk = 1'b0;
	logic                   rst = 1'b1;
	logic [7:0]             addr = 8'h00;
	logic [7:0]             wr_data = 8'h00;
	logic                   wr_en = 1'b0;
	logic                   rd_en = 1'b0;
	logic [7:0]             rd_data;
	logic                   irq;
	logic                   remote_one_fault = 1'b0;
	logic                   remote_two_fault = 1'b0;
	logic                   adc_done;
	logic [9:0]             adc_code;
	temp_fmt_pkg::adc_req_t adc_req;
	logic [35:0]            temp_q = 36'h0;
	int                     err_count = 0;
	int                     num_checks = 0;
	int                     seed = 32'h743b;
	int                     tq[3];
	int                     ofs[3];
	int                     ot[3];
	int                     oo[3];
	bit                     compat;
	bit                     oc;
	logic [2:0]             flt;
	logic [2:0]             ofl;
	logic [7:0]             d;
	logic [7:0]             ext;
	logic [9:0]             e;

	temp_result_formatter #(.SETTLE_CYC(SETTLE_CYC), .AVG_COUNT(AVG_COUNT))
	i_temp_result_formatter (.clk(clk), .rst(rst), .addr(addr),
		.wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
		.irq(irq), .remote_one_fault(remote_one_fault),
		.remote_two_fault(remote_two_fault), .adc_done(adc_done),
		.adc_code(adc_code), .adc_req(adc_req));

	diode_front_model i_diode_front_model (.clk(clk), .rst(rst),
		.adc_req(adc_req), .temp_q(temp_q), .adc_done(adc_done),
		.adc_code(adc_code));

	initial forever #20 clk = ~clk;

	// ---------------------------------------------------------------
	// bus cycles, expectations and comparison
	// ---------------------------------------------------------------
	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(string n, logic [9:0] x, logic [9:0] s);
		num_checks++;
		if (s !== x) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", n, x, s);
		end
	endtask

	task automatic wr(logic [7:0] a, logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wr_data <= v;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rd(logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 v = rd_data;
	endtask

	function automatic logic [9:0] enc(int t, int o, bit c, logic f);
		int v;
		v = t + 2 * o;
		if (c) begin
			if (f) return 10'h200;
			v = v < -252 ? -252 : (v > 511 ? 511 : v);
			return v[9:0];
		end
		if (f) return 10'h000;
		v = v + 256;
		v = v < 4 ? 4 : (v > 1023 ? 1023 : v);
		return v[9:0];
	endfunction

	// a result may straddle a change, so two rounds give clean values
	task automatic wait_new;
		for (int r = 0; r < 2; r++) begin
			d = 8'h00;
			wr(8'h7e, 8'h07);
			for (int i = 0; i < 3000 && d[2:0] !== 3'b111; i++)
				rd(8'h7e, d);
			if (d[2:0] !== 3'b111) begin
				chk("status wait", 10'h7, {7'h0, d[2:0]});
				end_sim;
			end
		end
	endtask

	task automatic setcfg;
		for (int c = 0; c < 3; c++)
			wr(8'(8'h70 + c), ofs[c][7:0]);
		wr(8'h7c, {6'h00, compat, 1'b0});
		temp_q <= {tq[2][11:0], tq[1][11:0], tq[0][11:0]};
		remote_one_fault <= flt[0];
		remote_two_fault <= flt[2];
		wait_new;
	endtask

	task automatic check_vals(int t[3], int o[3], bit c, logic [2:0] f);
		rd(8'h77, ext);
		chk("ext unused", 10'h0, {8'h00, ext[1:0]});
		for (int ch = 0; ch < 3; ch++) begin
			e = enc(t[ch], o[ch], c, f[ch]);
			rd(8'(8'h25 + ch), d);
			chk("value", {2'b00, e[9:2]}, {2'b00, d});
			chk("ext", {8'h00, e[1:0]}, {8'h00, ext[2*ch+2 +: 2]});
		end
	endtask

	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		for (int c = 0; c < 3; c++) begin
			rd(8'(8'h70 + c), d);
			chk("offset reset", 10'h0, {2'b00, d});
		end
		rd(8'h7c, d);
		chk("cfg5 reset", 10'h0, {2'b00, d});
		rd(8'h60, d);
		chk("unmapped", 10'h0, {2'b00, d});
		tq = '{0, 0, 0};
		ofs = '{0, 0, 0};
		check_vals(tq, ofs, 1'b0, 3'b111);
		for (int r = 0; r < 6; r++) begin
			if (r == 0) begin
				tq = '{-248, 600, 0};
				ofs = '{-10, 0, 0};
				compat = 1'b1;
				flt = 3'b100;
			end else if (r == 1) begin
				tq = '{0, 760, -248};
				ofs = '{0, 127, -10};
				compat = 1'b0;
				flt = 3'b001;
			end else begin
				for (int c = 0; c < 3; c++) begin
					tq[c] = (($random(seed) & 1023) % 1009) - 248;
					ofs[c] = $random(seed) % 64 + $random(seed) % 64;
				end
				compat = $random(seed) & 1;
				flt = 3'b000;
			end
			setcfg;
			wr(8'h25, 8'hff);
			check_vals(tq, ofs, compat, flt);
			rd(8'h7e, d);
			for (int c = 0; c < 3; c++)
				if (flt[c])
					chk("fault status", 10'h1, {9'h0, d[3 + c]});
		end
		rd(8'h77, ext);
		ot = tq;
		oo = ofs;
		oc = compat;
		ofl = flt;
		tq = '{tq[1], tq[2], tq[0]};
		setcfg;
		for (int ch = 0; ch < 3; ch++) begin
			e = enc(ot[ch], oo[ch], oc, ofl[ch]);
			rd(8'(8'h25 + ch), d);
			chk("frozen value", {2'b00, e[9:2]}, {2'b00, d});
		end
		repeat (4) @(posedge clk);
		check_vals(tq, ofs, compat, flt);
		wr(8'h7f, 8'h00);
		wr(8'h7e, 8'h3f);
		repeat (3) @(posedge clk);
		#1 chk("irq masked", 10'h0, {9'h0, irq});
		wr(8'h7f, 8'h02);
		for (int i = 0; i < 3000 && irq !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		chk("irq raised", 10'h1, {9'h0, irq});
		if (irq !== 1'b1)
			end_sim;
		rd(8'h7e, d);
		chk("irq source", 10'h1, {9'h0, d[1]});
		wr(8'h7e, 8'h02);
		@(posedge clk);
		#1 chk("irq cleared", 10'h0, {9'h0, irq});
		end_sim;
	end

endmodule // tb

bind temp_result_formatter temp_fmt_checker #(.SETTLE_CYC(SETTLE_CYC),
	.AVG_COUNT(AVG_COUNT)) i_temp_fmt_checker (.clk(clk), .rst(rst),
	.addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
	.rd_data(rd_data), .irq(irq), .remote_one_fault(remote_one_fault),
	.remote_two_fault(remote_two_fault), .adc_done(adc_done),
	.adc_code(adc_code), .adc_req(adc_req));

/* File: dv/temp_fmt_assertions.sv */
// concurrent checks on the ports of the temperature result formatter
`timescale 1ns/1ns

module temp_fmt_checker #(
	parameter int SETTLE_CYC = 8,
	parameter int AVG_COUNT  = 16
) (
	input wire logic                   clk,
	input wire logic                   rst,
	input wire logic [7:0]             addr,
	input wire logic [7:0]             wr_data,
	input wire logic                   wr_en,
	input wire logic                   rd_en,
	input wire logic [7:0]             rd_data,
	input wire logic                   irq,
	input wire logic                   remote_one_fault,
	input wire logic                   remote_two_fault,
	input wire logic                   adc_done,
	input wire logic [9:0]             adc_code,
	input wire temp_fmt_pkg::adc_req_t adc_req
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	logic [5:0]          mask_sh;
	logic                ofs_wr;
	logic                cfg_wr;
	temp_fmt_pkg::cur_t  cur_p1;
	temp_fmt_pkg::cur_t  cur_p2;
	temp_fmt_pkg::chan_t chan_p1;

	// shadows of what software wrote and of the last two current steps
	always_ff @(posedge clk) begin
		if (rst) begin
			mask_sh <= 6'h00;
			ofs_wr  <= 1'b0;
			cfg_wr  <= 1'b0;
			cur_p1  <= temp_fmt_pkg::CUR_BASE;
			cur_p2  <= temp_fmt_pkg::CUR_BASE;
			chan_p1 <= temp_fmt_pkg::CH_REMOTE_ONE;
		end else begin
			if (wr_en && addr == 8'h7f)
				mask_sh <= wr_data[5:0];
			if (wr_en && addr == 8'h70)
				ofs_wr <= 1'b1;
			if (wr_en && addr == 8'h7c)
				cfg_wr <= 1'b1;
			if (adc_req.start) begin
				cur_p1  <= adc_req.cur;
				cur_p2  <= cur_p1;
				chan_p1 <= adc_req.chan;
			end
		end
	end

	sequence s_rd(a);
		rd_en && addr == a;
	endsequence

	// a read of a register that software has not written yet
	sequence s_rd_fresh(a, w);
		rd_en && addr == a && !w;
	endsequence

	a_rd_quiet_zero: assert property (!rd_en |=> rd_data == 8'h00)
		else $error("read data not zero outside a read");
	a_ext_low_zero: assert property (s_rd(8'h77) |=> rd_data[1:0] == 2'b00)
		else $error("unused low bits of shared register set");
	a_ofs_reset: assert property (s_rd_fresh(8'h70, ofs_wr) |=> rd_data == 8'h00)
		else $error("offset not zero after reset");
	a_compat_reset: assert property (s_rd_fresh(8'h7c, cfg_wr) |=> !rd_data[1])
		else $error("format bit not clear after reset");
	a_start_pulse: assert property (adc_req.start |=> !adc_req.start)
		else $error("conversion start longer than one cycle");
	a_req_settled: assert property (adc_req.start |->
		$stable(adc_req.cur) && $stable(adc_req.chan))
		else $error("current or channel moved at conversion start");
	a_mult_after_base: assert property (adc_req.start &&
		adc_req.cur != temp_fmt_pkg::CUR_BASE |->
		cur_p1 == temp_fmt_pkg::CUR_BASE && chan_p1 == adc_req.chan)
		else $error("multiple current step not preceded by base step");
	a_second_order: assert property (adc_req.start &&
		adc_req.cur == temp_fmt_pkg::CUR_SECOND_MULT |->
		cur_p2 == temp_fmt_pkg::CUR_FIRST_MULT)
		else $error("second multiple step before first multiple step");
	a_local_base: assert property (adc_req.start &&
		adc_req.chan == temp_fmt_pkg::CH_LOCAL |->
		adc_req.cur == temp_fmt_pkg::CUR_BASE)
		else $error("local conversion not at base current");
	a_irq_masked: assert property (mask_sh == 6'h00 ##1 mask_sh == 6'h00 |-> !irq)
		else $error("interrupt high with all sources masked");

endmodule // temp_fmt_checker

/* File: inc/temp_fmt_map.svh */
// offsets, field positions, reset values and counts of the temperature block
`ifndef TEMP_FMT_MAP_SVH
`define TEMP_FMT_MAP_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define TF_ADDR_VAL_R1     8'h25
`define TF_ADDR_VAL_LOC    8'h26
`define TF_ADDR_VAL_R2     8'h27
`define TF_ADDR_OFS_R1     8'h70
`define TF_ADDR_OFS_LOC    8'h71
`define TF_ADDR_OFS_R2     8'h72
`define TF_ADDR_EXT_LSBS   8'h77
`define TF_ADDR_CFG5       8'h7c
`define TF_ADDR_IRQ_STAT   8'h7e
`define TF_ADDR_IRQ_MASK   8'h7f

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define TF_CFG5_COMPAT_BIT 1
`define TF_EXT_R2_HI       7
`define TF_EXT_R2_LO       6
`define TF_EXT_LOC_HI      5
`define TF_EXT_LOC_LO      4
`define TF_EXT_R1_HI       3
`define TF_EXT_R1_LO       2
`define TF_OFS_RESET       8'h00
`define TF_VAL_RESET       10'h000
`define TF_IRQ_NEW_LSB     0
`define TF_IRQ_FAULT_LSB   3

// ---------------------------------------------------------------
// encodings in quarter degrees, averaging and settling counts
// ---------------------------------------------------------------
`define TF_AVG_COUNT       16
`define TF_AVG_SHIFT       4
`define TF_EXT_BIAS_Q      13'sd256
`define TF_TC_MIN_Q        (-13'sd252)
`define TF_TC_MAX_Q        13'sd511
`define TF_EXT_MIN_Q       13'sd4
`define TF_EXT_MAX_Q       13'sd1023
`define TF_TC_FAULT        10'h200
`define TF_EXT_FAULT       10'h000
`define TF_SETTLE_CYC      8

`endif

/* File: inc/temp_fmt_pkg.sv */
// types shared by the temperature result formatter and its sequencer
package temp_fmt_pkg;

	typedef enum logic [1:0] {
		CH_REMOTE_ONE,
		CH_LOCAL,
		CH_REMOTE_TWO
	} chan_t;

	typedef enum logic [1:0] {
		CUR_BASE,
		CUR_FIRST_MULT,
		CUR_SECOND_MULT
	} cur_t;

	typedef enum logic [1:0] {
		SQ_IDLE,
		SQ_SETTLE,
		SQ_CONV,
		SQ_DONE
	} seq_st_t;

	// converter request toward the analog front end
	typedef struct packed {
		logic  start;
		chan_t chan;
		cur_t  cur;
	} adc_req_t;

	typedef struct packed {
		seq_st_t            st;
		chan_t              chan;
		logic [1:0]         phase;
		logic [7:0]         wait_cnt;
		logic [3:0][9:0]    smp;
		adc_req_t           req;
		logic               res_valid;
		logic signed [11:0] res_raw;
	} seq_state_t;

	typedef struct packed {
		chan_t              chan;
		logic               busy;
		logic [3:0]         cnt;
		logic signed [15:0] acc;
		logic               fault_seen;
		logic [2:0][7:0]    offset;
		logic [2:0][9:0]    value;
		logic [2:0][9:0]    shadow;
		logic [2:0]         pend;
		logic               frozen;
		logic [2:0]         unread;
		logic               compat;
		logic [5:0]         status;
		logic [5:0]         mask;
		logic [7:0]         rd_data;
		logic               irq;
		logic               meas_req;
	} fmt_state_t;

endpackage

/* File: logic/diode_excite_seq.sv */
// excitation current sequencer and difference extraction for one measurement
`timescale 1ns/1ns
`include "temp_fmt_map.svh"

module diode_excite_seq #(
	parameter int SETTLE_CYC = `TF_SETTLE_CYC
) (
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic                 meas_req,
	input  wire temp_fmt_pkg::chan_t  meas_chan,
	input  wire logic                 adc_done,
	input  wire logic [9:0]           adc_code,
	output temp_fmt_pkg::adc_req_t    adc_req,
	output logic                      res_valid,
	output logic signed [11:0]        res_raw
);

	temp_fmt_pkg::seq_state_t s_r;
	temp_fmt_pkg::seq_state_t s_nxt;
	logic signed [12:0]       d_first;
	logic signed [12:0]       d_second;
	logic signed [12:0]       combo;

	// ---------------------------------------------------------------
	// phase 0 base, 1 first multiple, 2 base, 3 second multiple
	// ---------------------------------------------------------------
	function automatic temp_fmt_pkg::cur_t cur_of(input logic [1:0] ph);
		unique case (ph)
			2'h1:    cur_of = temp_fmt_pkg::CUR_FIRST_MULT;
			2'h3:    cur_of = temp_fmt_pkg::CUR_SECOND_MULT;
			default: cur_of = temp_fmt_pkg::CUR_BASE;
		endcase
	endfunction

	// series resistance drops out of twice the first step minus the second
	assign d_first  = 13'(signed'({1'b0, s_r.smp[1]})) -
	                  13'(signed'({1'b0, s_r.smp[0]}));
	assign d_second = 13'(signed'({1'b0, s_r.smp[3]})) -
	                  13'(signed'({1'b0, s_r.smp[2]}));
	assign combo    = 13'(d_first <<< 1) - d_second;

	always_comb begin
		s_nxt               = s_r;
		s_nxt.req.start     = 1'b0;
		s_nxt.res_valid     = 1'b0;
		unique case (s_r.st)
			temp_fmt_pkg::SQ_IDLE: begin
				if (meas_req) begin
					s_nxt.chan     = meas_chan;
					s_nxt.phase    = 2'h0;
					s_nxt.wait_cnt = 8'h00;
					s_nxt.req.chan = meas_chan;
					s_nxt.req.cur  = temp_fmt_pkg::CUR_BASE;
					s_nxt.st       = temp_fmt_pkg::SQ_SETTLE;
				end
			end
			temp_fmt_pkg::SQ_SETTLE: begin
				if (s_r.wait_cnt == 8'(SETTLE_CYC - 1)) begin
					s_nxt.req.start = 1'b1;
					s_nxt.st        = temp_fmt_pkg::SQ_CONV;
				end else begin
					s_nxt.wait_cnt = s_r.wait_cnt + 8'h01;
				end
			end
			temp_fmt_pkg::SQ_CONV: begin
				if (adc_done) begin
					s_nxt.smp[s_r.phase] = adc_code;
					if (s_r.chan == temp_fmt_pkg::CH_LOCAL ||
					    s_r.phase == 2'h3) begin
						s_nxt.req.cur = temp_fmt_pkg::CUR_BASE;
						s_nxt.st      = temp_fmt_pkg::SQ_DONE;
					end else begin
						s_nxt.phase    = s_r.phase + 2'h1;
						s_nxt.req.cur  = cur_of(s_r.phase + 2'h1);
						s_nxt.wait_cnt = 8'h00;
						s_nxt.st       = temp_fmt_pkg::SQ_SETTLE;
					end
				end
			end
			temp_fmt_pkg::SQ_DONE: begin
				s_nxt.res_valid = 1'b1;
				if (s_r.chan == temp_fmt_pkg::CH_LOCAL)
					s_nxt.res_raw = 12'(signed'({2'b00, s_r.smp[0]}) -
					                    `TF_EXT_BIAS_Q);
				else
					s_nxt.res_raw = combo[11:0];
				s_nxt.st = temp_fmt_pkg::SQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_r           <= '0;
			s_r.st        <= temp_fmt_pkg::SQ_IDLE;
			s_r.req.cur   <= temp_fmt_pkg::CUR_BASE;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign adc_req   = s_r.req;
	assign res_valid = s_r.res_valid;
	assign res_raw   = s_r.res_raw;

endmodule // diode_excite_seq

/* File: logic/temp_result_formatter.sv */
// temperature averaging, offset, formatting and result register file
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ns
`include "temp_fmt_map.svh"

// What this block does
// - each result is ten bits, eight upper bits in the value register and two quarter-degree bits.
// - twos complement uses one degree per step, zero at all zeros, and 1000 0000 00 for a diode fault.
// - extended range adds 64 degrees, spans -63 to +191 and keeps all zeros for a diode fault.
// - sixteen consecutive measurements are averaged before a value register changes.
// - the two extra resolution bits of each result sit in the shared register at 0x77.
// - a remote measurement steps base to first multiple, then base to second multiple, and combines both steps.
// - a channel's signed offset is added to every measurement of that channel before storing.
// - the compatibility bit selects twos complement clamped to -63..+127, otherwise offset-64.
// - the shared register holds remote two in 7:6, local in 5:4 and remote one in 3:2.
// - reading the shared register freezes all value registers until each has been read.
// - offset registers are 8-bit twos complement, half a degree per step, reset to zero.
module temp_result_formatter #(
	parameter int SETTLE_CYC = `TF_SETTLE_CYC,
	parameter int AVG_COUNT  = `TF_AVG_COUNT
) (
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic [7:0]         addr,
	input  wire logic [7:0]         wr_data,
	input  wire logic               wr_en,
	input  wire logic               rd_en,
	output logic [7:0]              rd_data,
	output logic                    irq,
	input  wire logic               remote_one_fault,
	input  wire logic               remote_two_fault,
	input  wire logic               adc_done,
	input  wire logic [9:0]         adc_code,
	output temp_fmt_pkg::adc_req_t  adc_req
);

	// all state of the block except the fault synchronisers, filled in one place and registered in one
	typedef temp_fmt_pkg::fmt_state_t fmt_state_t_alias;

	fmt_state_t_alias   s_r;
	fmt_state_t_alias   s_nxt;
	logic [1:0]         f1_sync_r;
	logic [1:0]         f2_sync_r;
	logic               res_valid;
	logic signed [11:0] res_raw;
	logic signed [15:0] acc_sum;
	logic signed [12:0] avg_q;
	logic signed [12:0] corr_q;
	logic [9:0]         fmt_code;
	logic               cur_fault;
	logic [2:0]         ev_new;
	logic [2:0]         ev_fault;
	logic [2:0]         rd_val_hit;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// value register address to channel one-hot, used by the freeze release on value reads
	function automatic logic [2:0] val_hit(input logic [7:0] a);
		val_hit = {a == `TF_ADDR_VAL_R2, a == `TF_ADDR_VAL_LOC,
		           a == `TF_ADDR_VAL_R1};
	endfunction

	function automatic int unsigned chan_idx(input temp_fmt_pkg::chan_t c);
		unique case (c)
			temp_fmt_pkg::CH_REMOTE_ONE: chan_idx = 0;
			temp_fmt_pkg::CH_LOCAL:      chan_idx = 1;
			temp_fmt_pkg::CH_REMOTE_TWO: chan_idx = 2;
			default:                     chan_idx = 0;
		endcase
	endfunction

	function automatic temp_fmt_pkg::chan_t chan_next(
		input temp_fmt_pkg::chan_t c);
		unique case (c)
			temp_fmt_pkg::CH_REMOTE_ONE: chan_next = temp_fmt_pkg::CH_LOCAL;
			temp_fmt_pkg::CH_LOCAL:      chan_next = temp_fmt_pkg::CH_REMOTE_TWO;
			default:                     chan_next = temp_fmt_pkg::CH_REMOTE_ONE;
		endcase
	endfunction

	// quarter-degree reading to ten-bit code in the selected encoding
	function automatic logic [9:0] encode(input logic signed [12:0] q,
	                                     input logic fault,
	                                     input logic compat);
		logic signed [12:0] e;
		e = 13'sd0;
		if (compat) begin
			if (fault)
				encode = `TF_TC_FAULT;
			else if (q < `TF_TC_MIN_Q)
				encode = 10'(`TF_TC_MIN_Q);
			else if (q > `TF_TC_MAX_Q)
				encode = 10'(`TF_TC_MAX_Q);
			else
				encode = q[9:0];
		end else begin
			e = q + `TF_EXT_BIAS_Q;
			if (fault)
				encode = `TF_EXT_FAULT;
			else if (e < `TF_EXT_MIN_Q)
				encode = 10'(`TF_EXT_MIN_Q);
			else if (e > `TF_EXT_MAX_Q)
				encode = 10'(`TF_EXT_MAX_Q);
			else
				encode = e[9:0];
		end
	endfunction

	// ---------------------------------------------------------------
	// fault pins come from the analog side, so two flops each
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			f1_sync_r <= 2'h0;
			f2_sync_r <= 2'h0;
		end else begin
			f1_sync_r <= {f1_sync_r[0], remote_one_fault};
			f2_sync_r <= {f2_sync_r[0], remote_two_fault};
		end
	end

	always_comb begin
		unique case (s_r.chan)
			temp_fmt_pkg::CH_REMOTE_ONE: cur_fault = f1_sync_r[1];
			temp_fmt_pkg::CH_REMOTE_TWO: cur_fault = f2_sync_r[1];
			default:                     cur_fault = 1'b0;
		endcase
	end

	// ---------------------------------------------------------------
	// measurement sequencer
	// ---------------------------------------------------------------
	diode_excite_seq #(
		.SETTLE_CYC (SETTLE_CYC)
	) u_seq (
		.clk       (clk),
		.rst       (rst),
		.meas_req  (s_r.meas_req),
		.meas_chan (s_r.chan),
		.adc_done  (adc_done),
		.adc_code  (adc_code),
		.adc_req   (adc_req),
		.res_valid (res_valid),
		.res_raw   (res_raw)
	);

	// ---------------------------------------------------------------
	// averaging and offset
	// ---------------------------------------------------------------
	assign acc_sum = s_r.acc + 16'(res_raw);
	assign avg_q   = 13'(acc_sum >>> `TF_AVG_SHIFT);
	// offset step is half a degree, two quarter-degree steps
	assign corr_q  = avg_q +
	                 13'(signed'({s_r.offset[chan_idx(s_r.chan)], 1'b0}));
	assign fmt_code = encode(corr_q, s_r.fault_seen | cur_fault, s_r.compat);
	assign rd_val_hit = rd_en ? val_hit(addr) : 3'h0;

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		s_nxt          = s_r;
		s_nxt.meas_req = 1'b0;
		ev_new         = 3'h0;
		ev_fault       = 3'h0;

		// start the next measurement once the last result came back
		if (!s_r.busy) begin
			s_nxt.meas_req = 1'b1;
			s_nxt.busy     = 1'b1;
		end

		if (res_valid) begin
			s_nxt.busy       = 1'b0;
			s_nxt.fault_seen = s_r.fault_seen | cur_fault;
			if (s_r.cnt == 4'(AVG_COUNT - 1)) begin
				// complete result moves as one ten-bit word
				s_nxt.shadow[chan_idx(s_r.chan)] = fmt_code;
				s_nxt.pend[chan_idx(s_r.chan)]   = 1'b1;
				ev_new[chan_idx(s_r.chan)]       = 1'b1;
				ev_fault[chan_idx(s_r.chan)]     = s_r.fault_seen | cur_fault;
				s_nxt.acc        = 16'sd0;
				s_nxt.cnt        = 4'h0;
				s_nxt.fault_seen = 1'b0;
				s_nxt.chan       = chan_next(s_r.chan);
			end else begin
				s_nxt.acc = acc_sum;
				s_nxt.cnt = s_r.cnt + 4'h1;
			end
		end

		// freeze: a shared-register read arms it, value reads release it
		if (rd_en && addr == `TF_ADDR_EXT_LSBS) begin
			s_nxt.frozen = 1'b1;
			s_nxt.unread = 3'h7;
		end else if (s_r.frozen) begin
			s_nxt.unread = s_r.unread & ~rd_val_hit;
			if ((s_r.unread & ~rd_val_hit) == 3'h0)
				s_nxt.frozen = 1'b0;
		end

		// an extended read in this cycle already holds them back
		if (!s_nxt.frozen) begin
			for (int i = 0; i < 3; i++) begin
				if (s_nxt.pend[i]) begin
					s_nxt.value[i] = s_nxt.shadow[i];
					s_nxt.pend[i]  = 1'b0;
				end
			end
		end

		// register writes
		if (wr_en) begin
			unique case (addr)
				`TF_ADDR_OFS_R1:  s_nxt.offset[0] = wr_data;
				`TF_ADDR_OFS_LOC: s_nxt.offset[1] = wr_data;
				`TF_ADDR_OFS_R2:  s_nxt.offset[2] = wr_data;
				`TF_ADDR_CFG5:
					s_nxt.compat = wr_data[`TF_CFG5_COMPAT_BIT];
				`TF_ADDR_IRQ_MASK: s_nxt.mask = wr_data[5:0];
				`TF_ADDR_IRQ_STAT: s_nxt.status = s_r.status & ~wr_data[5:0];
				default: ;
			endcase
		end
		// a new event beats a clear in the same cycle
		s_nxt.status = s_nxt.status | {ev_fault, ev_new};
		s_nxt.irq    = |(s_nxt.status & s_nxt.mask);

		// register reads, data stands one cycle later
		s_nxt.rd_data = 8'h00;
		if (rd_en) begin
			unique case (addr)
				`TF_ADDR_VAL_R1:   s_nxt.rd_data = s_r.value[0][9:2];
				`TF_ADDR_VAL_LOC:  s_nxt.rd_data = s_r.value[1][9:2];
				`TF_ADDR_VAL_R2:   s_nxt.rd_data = s_r.value[2][9:2];
				`TF_ADDR_OFS_R1:   s_nxt.rd_data = s_r.offset[0];
				`TF_ADDR_OFS_LOC:  s_nxt.rd_data = s_r.offset[1];
				`TF_ADDR_OFS_R2:   s_nxt.rd_data = s_r.offset[2];
				`TF_ADDR_EXT_LSBS: begin
					s_nxt.rd_data[`TF_EXT_R2_HI:`TF_EXT_R2_LO] =
						s_r.value[2][1:0];
					s_nxt.rd_data[`TF_EXT_LOC_HI:`TF_EXT_LOC_LO] =
						s_r.value[1][1:0];
					s_nxt.rd_data[`TF_EXT_R1_HI:`TF_EXT_R1_LO] =
						s_r.value[0][1:0];
				end
				`TF_ADDR_CFG5:
					s_nxt.rd_data[`TF_CFG5_COMPAT_BIT] = s_r.compat;
				`TF_ADDR_IRQ_STAT: s_nxt.rd_data = {2'b00, s_r.status};
				`TF_ADDR_IRQ_MASK: s_nxt.rd_data = {2'b00, s_r.mask};
				default:           s_nxt.rd_data = 8'h00;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			s_r           <= '0;
			s_r.chan      <= temp_fmt_pkg::CH_REMOTE_ONE;
			s_r.offset    <= {3{`TF_OFS_RESET}};
			s_r.value     <= {3{`TF_VAL_RESET}};
			s_r.shadow    <= {3{`TF_VAL_RESET}};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rd_data = s_r.rd_data;
	assign irq     = s_r.irq;

endmodule // temp_result_formatter
